/* addr_gen_pkg.sv */
/*
 Constants, types and shared arithmetic for the operand and jump address generator.
 Assumes an 8-bit data path and a 15-bit program address.
*/
`default_nettype none

package addr_gen_pkg;

   // ----------------------------------------------------------------
   // Widths and constants
   // ----------------------------------------------------------------
   localparam int PC_W = 15;
   localparam int DATA_W = 8;
   localparam int NIBBLE_W = 4;
   localparam int DIST_W = 6;
   localparam int ABS_W = 12;
   localparam int PAGE_LO = 8;

   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [14:0] PC_ONE = 15'h0001;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [5:0] DIST_POS_MAX = 6'h20;
   localparam logic [8:0] DIST_NEG_EXT = 9'h1FF;
   localparam logic [8:0] DIST_POS_EXT = 9'h000;
   localparam logic [6:0] DIST_SPAN = 7'h40;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_STEP,
      MODE_DIRECT,
      MODE_INDIRECT,
      MODE_POST_ADJUST,
      MODE_IMMEDIATE,
      MODE_SHORT_LOAD,
      MODE_TABLE_LOAD,
      MODE_JUMP_REL,
      MODE_JUMP_ABS,
      MODE_JUMP_LONG,
      MODE_JUMP_TABLE,
      MODE_VECTOR
   } op_mode_t;

   typedef enum logic [2:0] {
      USE_IMM,
      USE_TABLE,
      USE_JUMP_TABLE,
      USE_VEC_HI,
      USE_VEC_LO
   } rd_use_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_ISSUED,
      ST_RD_DATA
   } state_t;

   // ----------------------------------------------------------------
   // Relative distance
   // ----------------------------------------------------------------
   // Field codes 0 to 32 are forward, 33 to 63 are -31 to -1.
   function automatic logic [14:0] rel_distance(input logic [5:0] field);
      if (field > DIST_POS_MAX) begin
         rel_distance = {DIST_NEG_EXT, field};
      end else begin
         rel_distance = {DIST_POS_EXT, field};
      end
   endfunction : rel_distance

endpackage : addr_gen_pkg

`default_nettype wire

/* addr_gen_if.sv */
/*
 Internal carrier between the address generator core, its pointer pair and its jump target unit.
 Assumes all three parties run on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface addr_gen_if;
   logic ptr_load;
   logic ptr_load_sel;
   logic [7:0] ptr_load_value;
   logic ptr_adj;
   logic ptr_adj_sel;
   logic ptr_adj_dec;
   logic [7:0] ptr_first;
   logic [7:0] ptr_second;
   addr_gen_pkg::op_mode_t tgt_mode;
   logic [14:0] tgt_pc;
   logic [14:0] tgt_field;
   logic [14:0] tgt_next;

   modport core (
      output ptr_load, ptr_load_sel, ptr_load_value, ptr_adj, ptr_adj_sel, ptr_adj_dec,
      input ptr_first, ptr_second,
      output tgt_mode, tgt_pc, tgt_field,
      input tgt_next
   );

   modport ptr (
      input ptr_load, ptr_load_sel, ptr_load_value, ptr_adj, ptr_adj_sel, ptr_adj_dec,
      output ptr_first, ptr_second
   );

   modport tgt (
      input tgt_mode, tgt_pc, tgt_field,
      output tgt_next
   );
endinterface : addr_gen_if

`default_nettype wire

/* pointer_pair.sv */
/*
 The two data memory pointer registers with load and post-adjust.
 Assumes load and adjust requests are one-cycle pulses from the core.
*/
`timescale 1ns/1ps
`default_nettype none

module pointer_pair #(
   parameter int PTR_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   addr_gen_if.ptr bus
);

   if (PTR_W != addr_gen_pkg::DATA_W) begin : g_bad_width
      $error("Pointer width must equal the data width.");
   end

   // Wraps modulo 256 and touches no flag.
   function automatic logic [7:0] step(input logic [7:0] value, input logic dec);
      if (dec) begin
         step = 8'(value - addr_gen_pkg::PTR_STEP);
      end else begin
         step = 8'(value + addr_gen_pkg::PTR_STEP);
      end
   endfunction : step

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus.ptr_first <= addr_gen_pkg::PTR_RESET;
      end else if (bus.ptr_load && !bus.ptr_load_sel) begin
         bus.ptr_first <= bus.ptr_load_value;
      end else if (bus.ptr_adj && !bus.ptr_adj_sel) begin
         bus.ptr_first <= step(bus.ptr_first, bus.ptr_adj_dec);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus.ptr_second <= addr_gen_pkg::PTR_RESET;
      end else if (bus.ptr_load && bus.ptr_load_sel) begin
         bus.ptr_second <= bus.ptr_load_value;
      end else if (bus.ptr_adj && bus.ptr_adj_sel) begin
         bus.ptr_second <= step(bus.ptr_second, bus.ptr_adj_dec);
      end
   end

endmodule : pointer_pair

`default_nettype wire

/* jump_target.sv */
/*
 Combinational new program counter for relative, absolute and long jumps.
 Assumes the core registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module jump_target (
   addr_gen_if.tgt bus
);

   always_comb begin
      case (bus.tgt_mode)
         addr_gen_pkg::MODE_JUMP_REL: begin
            // Sum wraps inside the 15-bit program space.
            bus.tgt_next = 15'(bus.tgt_pc
               + addr_gen_pkg::rel_distance(bus.tgt_field[5:0]));
         end
         addr_gen_pkg::MODE_JUMP_ABS: begin
            bus.tgt_next = {bus.tgt_pc[14:12], bus.tgt_field[11:0]};
         end
         addr_gen_pkg::MODE_JUMP_LONG: begin
            bus.tgt_next = bus.tgt_field;
         end
         default: begin
            bus.tgt_next = bus.tgt_pc;
         end
      endcase
   end

endmodule : jump_target

`default_nettype wire

/* operand_and_jump_address_gen.sv */
/*
 Operand and jump address generator of an 8-bit core: data and program memory addresses,
 the two data pointers and the program counter.
 Assumes program memory returns read data in the cycle after the one in which pmem_req is high.
*/
`timescale 1ns/1ps
`default_nettype none

module operand_and_jump_address_gen (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic op_valid,
   output logic op_ready,
   input wire addr_gen_pkg::op_mode_t op_mode,
   input wire logic op_ptr_sel,
   input wire logic op_post_dec,
   input wire logic [1:0] op_len,
   input wire logic [14:0] op_field,
   input wire logic [7:0] accum,
   output logic dmem_req,
   output logic [7:0] dmem_addr,
   output logic pmem_req,
   output logic [14:0] pmem_addr,
   input wire logic [7:0] pmem_rdata,
   output logic operand_valid,
   output logic [7:0] operand_data,
   output logic accum_load,
   output logic [7:0] accum_data,
   output logic [7:0] pc_upper_byte,
   output logic [7:0] pc_lower_byte,
   output logic [7:0] ptr_first,
   output logic [7:0] ptr_second
);

   // ----------------------------------------------------------------
   // Declarations and sub-units
   // ----------------------------------------------------------------
   addr_gen_if link();

   addr_gen_pkg::state_t state;
   addr_gen_pkg::rd_use_t rd_use;
   logic [14:0] pc;
   logic [7:0] vec_hi;
   logic accept;
   logic [7:0] sel_ptr_val;
   logic [14:0] table_addr;
   logic [7:0] direct_byte;

   localparam int PC_LO_POS = addr_gen_pkg::PAGE_LO;

   pointer_pair #(
      .PTR_W(addr_gen_pkg::DATA_W)
   ) u_pointers (
      .core_clk(core_clk),
      .rst(rst),
      .bus(link)
   );

   jump_target u_target (
      .bus(link)
   );

   // ----------------------------------------------------------------
   // Handshake and request decode
   // ----------------------------------------------------------------
   // A new operation is taken only while no program memory read is in flight.
   assign op_ready = (state == addr_gen_pkg::ST_IDLE);
   assign accept = op_valid && op_ready;

   assign sel_ptr_val = op_ptr_sel ? link.ptr_second : link.ptr_first;
   // The accumulator stands in for the PC low byte only on the address lines; the PC
   // register itself never takes the accumulator, so its low byte needs no restore step.
   assign table_addr = {pc[14:PC_LO_POS], accum};
   assign direct_byte = op_field[7:0];

   always_comb begin
      link.ptr_load = accept && (op_mode == addr_gen_pkg::MODE_SHORT_LOAD);
      link.ptr_load_sel = 1'b0;
      link.ptr_load_value = {addr_gen_pkg::NIBBLE_ZERO, op_field[3:0]};
      link.ptr_adj = accept && (op_mode == addr_gen_pkg::MODE_POST_ADJUST);
      link.ptr_adj_sel = op_ptr_sel;
      link.ptr_adj_dec = op_post_dec;
      link.tgt_mode = op_mode;
      link.tgt_pc = pc;
      link.tgt_field = op_field;
   end

   assign ptr_first = link.ptr_first;
   assign ptr_second = link.ptr_second;

   // ----------------------------------------------------------------
   // Data memory address
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dmem_req <= 1'b0;
         dmem_addr <= addr_gen_pkg::BYTE_ZERO;
      end else begin
         dmem_req <= 1'b0;
         if (accept) begin
            if (op_mode == addr_gen_pkg::MODE_DIRECT) begin
               dmem_req <= 1'b1;
               dmem_addr <= direct_byte;
            end else if (op_mode == addr_gen_pkg::MODE_INDIRECT
                         || op_mode == addr_gen_pkg::MODE_POST_ADJUST) begin
               dmem_req <= 1'b1;
               // Old pointer value; in MODE_POST_ADJUST the pointer steps on this same edge.
               dmem_addr <= sel_ptr_val;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Program memory reads
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pmem_req <= 1'b0;
         pmem_addr <= addr_gen_pkg::PC_RESET;
      end else begin
         pmem_req <= 1'b0;
         if (accept) begin
            case (op_mode)
               addr_gen_pkg::MODE_IMMEDIATE: begin
                  pmem_req <= 1'b1;
                  pmem_addr <= 15'(pc + addr_gen_pkg::PC_ONE);
               end
               addr_gen_pkg::MODE_TABLE_LOAD, addr_gen_pkg::MODE_JUMP_TABLE: begin
                  pmem_req <= 1'b1;
                  pmem_addr <= table_addr;
               end
               addr_gen_pkg::MODE_VECTOR: begin
                  pmem_req <= 1'b1;
                  pmem_addr <= op_field;
               end
               default: begin
                  pmem_req <= 1'b0;
               end
            endcase
         end else if (state == addr_gen_pkg::ST_RD_DATA && rd_use == addr_gen_pkg::USE_VEC_HI) begin
            pmem_req <= 1'b1;
            pmem_addr <= 15'(pmem_addr + addr_gen_pkg::PC_ONE);
         end
      end
   end

   // ----------------------------------------------------------------
   // Read sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= addr_gen_pkg::ST_IDLE;
         rd_use <= addr_gen_pkg::USE_IMM;
      end else begin
         case (state)
            addr_gen_pkg::ST_IDLE: begin
               if (accept) begin
                  if (op_mode == addr_gen_pkg::MODE_IMMEDIATE) begin
                     state <= addr_gen_pkg::ST_RD_ISSUED;
                     rd_use <= addr_gen_pkg::USE_IMM;
                  end else if (op_mode == addr_gen_pkg::MODE_TABLE_LOAD) begin
                     state <= addr_gen_pkg::ST_RD_ISSUED;
                     rd_use <= addr_gen_pkg::USE_TABLE;
                  end else if (op_mode == addr_gen_pkg::MODE_JUMP_TABLE) begin
                     state <= addr_gen_pkg::ST_RD_ISSUED;
                     rd_use <= addr_gen_pkg::USE_JUMP_TABLE;
                  end else if (op_mode == addr_gen_pkg::MODE_VECTOR) begin
                     state <= addr_gen_pkg::ST_RD_ISSUED;
                     rd_use <= addr_gen_pkg::USE_VEC_HI;
                  end
               end
            end
            addr_gen_pkg::ST_RD_ISSUED: begin
               state <= addr_gen_pkg::ST_RD_DATA;
            end
            addr_gen_pkg::ST_RD_DATA: begin
               if (rd_use == addr_gen_pkg::USE_VEC_HI) begin
                  state <= addr_gen_pkg::ST_RD_ISSUED;
                  rd_use <= addr_gen_pkg::USE_VEC_LO;
               end else begin
                  state <= addr_gen_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= addr_gen_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read results
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         operand_valid <= 1'b0;
         operand_data <= addr_gen_pkg::BYTE_ZERO;
         accum_load <= 1'b0;
         accum_data <= addr_gen_pkg::BYTE_ZERO;
      end else begin
         operand_valid <= 1'b0;
         accum_load <= 1'b0;
         if (state == addr_gen_pkg::ST_RD_DATA) begin
            if (rd_use == addr_gen_pkg::USE_IMM) begin
               operand_valid <= 1'b1;
               operand_data <= pmem_rdata;
            end else if (rd_use == addr_gen_pkg::USE_TABLE) begin
               accum_load <= 1'b1;
               accum_data <= pmem_rdata;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         vec_hi <= addr_gen_pkg::BYTE_ZERO;
      end else if (state == addr_gen_pkg::ST_RD_DATA && rd_use == addr_gen_pkg::USE_VEC_HI) begin
         vec_hi <= pmem_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc <= addr_gen_pkg::PC_RESET;
      end else if (accept) begin
         case (op_mode)
            addr_gen_pkg::MODE_JUMP_REL, addr_gen_pkg::MODE_JUMP_ABS,
            addr_gen_pkg::MODE_JUMP_LONG: begin
               pc <= link.tgt_next;
            end
            addr_gen_pkg::MODE_JUMP_TABLE, addr_gen_pkg::MODE_VECTOR: begin
               pc <= pc;
            end
            default: begin
               pc <= 15'(pc + 15'(op_len));
            end
         endcase
      end else if (state == addr_gen_pkg::ST_RD_DATA) begin
         if (rd_use == addr_gen_pkg::USE_JUMP_TABLE) begin
            pc[7:0] <= pmem_rdata;
         end else if (rd_use == addr_gen_pkg::USE_VEC_LO) begin
            pc <= {vec_hi[6:0], pmem_rdata};
         end
      end
   end

   // The unused top bit of the upper byte always reads zero.
   assign pc_upper_byte = {1'b0, pc[14:PC_LO_POS]};
   assign pc_lower_byte = pc[7:0];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking main_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   logic [14:0] rel_expect;
   assign rel_expect = (op_field[5:0] > addr_gen_pkg::DIST_POS_MAX)
      ? 15'(pc - 15'(addr_gen_pkg::DIST_SPAN - 7'(op_field[5:0])))
      : 15'(pc + 15'(op_field[5:0]));

   direct_addr_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_DIRECT
      |=> dmem_req && dmem_addr == $past(direct_byte))
      else $error("Direct address not taken from the instruction byte.");

   indirect_addr_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_INDIRECT
      |=> dmem_req && dmem_addr == $past(sel_ptr_val) && ptr_first == $past(ptr_first))
      else $error("Indirect address does not match the selected pointer.");

   post_inc_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_POST_ADJUST && !op_ptr_sel && !op_post_dec
      |=> dmem_addr == $past(ptr_first)
          && ptr_first == 8'($past(ptr_first) + addr_gen_pkg::PTR_STEP))
      else $error("First pointer post-increment wrong.");

   post_dec_wrap_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_POST_ADJUST && op_ptr_sel && op_post_dec
      |=> ptr_second == 8'($past(ptr_second) - addr_gen_pkg::PTR_STEP)
          && ptr_first == $past(ptr_first))
      else $error("Second pointer post-decrement wrong.");

   imm_fetch_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_IMMEDIATE
      |=> pmem_req && pmem_addr == 15'($past(pc) + addr_gen_pkg::PC_ONE)
          ##2 operand_valid && operand_data == $past(pmem_rdata))
      else $error("Immediate operand not fetched after the opcode.");

   short_load_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_SHORT_LOAD
      |=> ptr_first[7:4] == addr_gen_pkg::NIBBLE_ZERO
          && ptr_first[3:0] == $past(op_field[3:0]))
      else $error("Short load did not set the nibble and clear the top.");

   table_load_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_TABLE_LOAD
      |=> pmem_addr == $past(table_addr) ##2 accum_load && pc == $past(pc, 2))
      else $error("Table load address or PC restore wrong.");

   pc_top_bit_a: assert property (
      !pc_upper_byte[7])
      else $error("Unused PC bit is set.");

   rel_jump_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_JUMP_REL
      |=> pc == $past(rel_expect))
      else $error("Relative jump target wrong.");

   abs_jump_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_JUMP_ABS
      |=> pc[14:12] == $past(pc[14:12]) && pc[11:0] == $past(op_field[11:0]))
      else $error("Absolute jump left its 4-kbyte space.");

   long_jump_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_JUMP_LONG
      |=> pc == $past(op_field))
      else $error("Long jump did not load all PC bits.");

   table_jump_a: assert property (
      state == addr_gen_pkg::ST_RD_DATA && rd_use == addr_gen_pkg::USE_JUMP_TABLE
      |=> pc_lower_byte == $past(pmem_rdata) && pc_upper_byte == $past(pc_upper_byte))
      else $error("Table jump did not load only the PC low byte.");

   vector_read_a: assert property (
      accept && op_mode == addr_gen_pkg::MODE_VECTOR
      |=> pmem_req && pmem_addr == $past(op_field)
          ##2 pmem_req && pmem_addr == 15'($past(pmem_addr, 2) + addr_gen_pkg::PC_ONE))
      else $error("Vector bytes not read from adjacent addresses.");

endmodule : operand_and_jump_address_gen

`default_nettype wire

/* pmem_model.sv */
/*
 Program memory model for the address generator bench.
 Assumes one core clock and an answer in the cycle after pmem_req.
*/
`timescale 1ns/1ps
`default_nettype none

module pmem_model (
   input wire logic core_clk,
   input wire logic pmem_req,
   input wire logic [14:0] pmem_addr,
   output logic [7:0] pmem_rdata
);
   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [7:0] held = 8'h3C;

   // Outside the answer cycle the byte toggles, so a late capture is caught.
   always @(posedge core_clk) begin
      if (pmem_req) begin
         held <= pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]} ^ 8'hA5;
      end else begin
         held <= ~held;
      end
   end
   assign pmem_rdata = held;
endmodule : pmem_model

`default_nettype wire

/* operand_and_jump_address_gen_tb.sv */
/*
 Self-checking bench for the operand and jump address generator.
 Assumes the program memory model answers one cycle after each read request.
*/
`timescale 1ns/1ps
`default_nettype none

module operand_and_jump_address_gen_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   logic op_ptr_sel = 1'b0;
   logic op_post_dec = 1'b0;
   logic [1:0] op_len = 2'h0;
   logic [14:0] op_field = 15'h0000;
   logic [7:0] accum = 8'h00;
   addr_gen_pkg::op_mode_t op_mode = addr_gen_pkg::MODE_STEP;
   logic op_ready, dmem_req, pmem_req, operand_valid, accum_load;
   logic [7:0] dmem_addr, pmem_rdata, operand_data, accum_data;
   logic [7:0] pc_upper_byte, pc_lower_byte, ptr_first, ptr_second;
   logic [14:0] pmem_addr;
   logic [14:0] pc = 15'h0000;
   logic [7:0] p [2] = '{8'h00, 8'h00};
   int miscompares = 0;
   int n_compared = 0;

   always #2 core_clk = ~core_clk;

   operand_and_jump_address_gen u_operand_and_jump_address_gen (.core_clk(core_clk), .rst(rst),
      .op_valid(op_valid), .op_ready(op_ready), .op_mode(op_mode), .op_ptr_sel(op_ptr_sel),
      .op_post_dec(op_post_dec), .op_len(op_len), .op_field(op_field), .accum(accum),
      .dmem_req(dmem_req), .dmem_addr(dmem_addr), .pmem_req(pmem_req), .pmem_addr(pmem_addr),
      .pmem_rdata(pmem_rdata), .operand_valid(operand_valid), .operand_data(operand_data),
      .accum_load(accum_load), .accum_data(accum_data), .pc_upper_byte(pc_upper_byte),
      .pc_lower_byte(pc_lower_byte), .ptr_first(ptr_first), .ptr_second(ptr_second));

   pmem_model u_pmem_model (.core_clk(core_clk), .pmem_req(pmem_req), .pmem_addr(pmem_addr),
      .pmem_rdata(pmem_rdata));

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] mem(input logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
   endfunction : mem

   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Offers one operation at a clock edge and checks its effects where they stand.
   task automatic run(input addr_gen_pkg::op_mode_t m, input logic s, input logic d,
         input logic [1:0] l, input logic [14:0] f, input logic [7:0] a);
      logic [14:0] npc, pa;
      logic [7:0] ea, hi;
      int rd, ds;
      logic dm;
      npc = pc + 15'(l);
      pa = 15'h0000;
      ea = 8'h00;
      rd = 0;
      ds = (f[5:0] > 6'h20) ? int'(f[5:0]) - 64 : int'(f[5:0]);
      dm = m inside {addr_gen_pkg::MODE_DIRECT, addr_gen_pkg::MODE_INDIRECT,
         addr_gen_pkg::MODE_POST_ADJUST};
      case (m)
         addr_gen_pkg::MODE_DIRECT: ea = f[7:0];
         addr_gen_pkg::MODE_INDIRECT, addr_gen_pkg::MODE_POST_ADJUST: ea = p[s];
         addr_gen_pkg::MODE_IMMEDIATE: begin rd = 1; pa = pc + 15'h0001; end
         addr_gen_pkg::MODE_TABLE_LOAD: begin rd = 2; pa = {pc[14:8], a}; end
         addr_gen_pkg::MODE_JUMP_REL: npc = pc + 15'(ds);
         addr_gen_pkg::MODE_JUMP_ABS: npc = {pc[14:12], f[11:0]};
         addr_gen_pkg::MODE_JUMP_LONG: npc = f;
         addr_gen_pkg::MODE_JUMP_TABLE: begin rd = 3; pa = {pc[14:8], a}; npc = pc; end
         addr_gen_pkg::MODE_VECTOR: begin rd = 4; pa = f; npc = pc; end
         default: ;
      endcase
      op_mode <= m;
      op_ptr_sel <= s;
      op_post_dec <= d;
      op_len <= l;
      op_field <= f;
      accum <= a;
      op_valid <= 1'b1;
      do @(posedge core_clk); while (op_ready !== 1'b1);
      op_valid <= 1'b0;
      @(posedge core_clk);
      if (m == addr_gen_pkg::MODE_POST_ADJUST) p[s] = d ? p[s] - 8'h01 : p[s] + 8'h01;
      if (m == addr_gen_pkg::MODE_SHORT_LOAD) p[0] = {4'h0, f[3:0]};
      if (rd != 4) chk("pc", {1'b0, npc}, {pc_upper_byte, pc_lower_byte});
      chk("dmem_req", 16'(dm), 16'(dmem_req));
      if (dm) chk("dmem_addr", 16'(ea), 16'(dmem_addr));
      chk("pointers", {p[0], p[1]}, {ptr_first, ptr_second});
      if (rd > 0) begin
         chk("pmem", {1'b1, pa}, {pmem_req, pmem_addr});
         repeat (2) @(posedge core_clk);
         if (rd == 4) begin
            chk("pmem_next", {1'b1, f + 15'h0001}, {pmem_req, pmem_addr});
            repeat (2) @(posedge core_clk);
            hi = mem(f);
            npc = {hi[6:0], mem(f + 15'h0001)};
         end
         if (rd == 1) chk("operand", {8'h01, mem(pa)}, {7'h0, operand_valid, operand_data});
         if (rd == 2) chk("accum", {8'h01, mem(pa)}, {7'h0, accum_load, accum_data});
         if (rd == 3) npc = {pc[14:8], mem(pa)};
         chk("pulses", 16'({rd == 1, rd == 2}), 16'({operand_valid, accum_load}));
         chk("pc_read", {1'b0, npc}, {pc_upper_byte, pc_lower_byte});
      end else begin
         chk("pmem_req", 16'h0000, 16'(pmem_req));
      end
      pc = npc;
   endtask : run

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      #100000;
      miscompares++;
      results();
   end

   initial begin
      addr_gen_pkg::op_mode_t m;
      logic [14:0] f;
      void'($urandom(32'hd3b5));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("reset", {1'b1, 15'h0000}, {op_ready, pc_upper_byte[6:0], pc_lower_byte});
      run(addr_gen_pkg::MODE_POST_ADJUST, 1'b0, 1'b1, 2'h1, 15'h0000, 8'h00);
      run(addr_gen_pkg::MODE_POST_ADJUST, 1'b0, 1'b0, 2'h1, 15'h0000, 8'h00);
      run(addr_gen_pkg::MODE_POST_ADJUST, 1'b1, 1'b1, 2'h1, 15'h0000, 8'h00);
      run(addr_gen_pkg::MODE_SHORT_LOAD, 1'b1, 1'b0, 2'h1, 15'h7FFA, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_REL, 1'b0, 1'b0, 2'h1, 15'h0021, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_REL, 1'b0, 1'b0, 2'h1, 15'h0020, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_REL, 1'b0, 1'b0, 2'h1, 15'h003F, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_LONG, 1'b0, 1'b0, 2'h3, 15'h7FFF, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_REL, 1'b0, 1'b0, 2'h1, 15'h0020, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_ABS, 1'b0, 1'b0, 2'h2, 15'h0125, 8'h00);
      run(addr_gen_pkg::MODE_JUMP_TABLE, 1'b0, 1'b0, 2'h1, 15'h0000, 8'hFF);
      run(addr_gen_pkg::MODE_TABLE_LOAD, 1'b0, 1'b0, 2'h1, 15'h0000, 8'h1F);
      run(addr_gen_pkg::MODE_VECTOR, 1'b0, 1'b0, 2'h1, 15'h1234, 8'h00);
      for (int i = 0; i < 300; i++) begin
         m = addr_gen_pkg::op_mode_t'($urandom_range(11, 0));
         f = 15'($urandom());
         if (m == addr_gen_pkg::MODE_JUMP_REL && f[5:0] == 6'h01) f[5:0] = 6'h00;
         run(m, 1'($urandom()), 1'($urandom()), 2'($urandom()), f, 8'($urandom()));
      end
      results();
   end
endmodule : operand_and_jump_address_gen_tb

`default_nettype wire
